// ==== logic/lcdsd_decoder.sv ====
// seven-digit character latch, pattern lookup and four-common lcd scan
// Behaviour
// - only the seven low nibbles of the working register are displayable, never the top one.
// - nibble 6 goes to digit 1 on selects 1/2, down to nibble 0 in digit 7 on selects 13/14.
// - odd selects carry C, F, H, E on commons 1 to 4.
// - the common and select assignment is fixed and the glass must be wired to match.
// - four commons by fourteen selects drive 56 segments with no software timing.
// - hardware refreshes the glass continuously in active and done modes.
// - a fixed 64 by 7 combinational table decodes codes into segments A to G.
// - segment H bypasses the table and comes from its own command bit.
// - codes 0 to 9 light the decimal digit shapes.
// - codes 10 to 20 light the letter shapes A to U with 16 blank.
// - codes 21 to 31 light the lower case and symbol shapes.
// - codes 32 to 59 light A,F,B,G,E from the binary of code minus 32; 60 to 63 fixed.
// - the layout makes one failed line show nonsense rather than another character.
`timescale 1ns/100ps
`default_nettype none
module lcdsd_decoder
	import lcdsd_pkg::*;
(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 resetn,
	// single digit load from the core
	input  wire logic                 digit_wr,
	input  wire logic [2:0]           digit_sel,
	input  wire logic [CODE_W-1:0]    digit_code,
	input  wire logic                 digit_h,
	// bulk load from the working register
	input  wire logic                 reg_wr,
	input  wire logic [4*NIBBLES-1:0] main_working_register,
	input  wire logic [DIGITS-1:0]    reg_h,
	// power mode: refresh runs unless off
	input  wire logic                 mode_off,
	// glass drive
	output logic [COMMONS-1:0]        com_on,
	output logic [SELECTS-1:0]        sel_on,
	output logic                      scan_active
);
	logic [CODE_W-1:0]      code_q [DIGITS];
	logic [DIGITS-1:0]      h_q;
	logic [PHASE_CNT_W-1:0] phase_cnt;
	logic [1:0]             com_idx;
	logic [SELECTS-1:0]     next_sel;

	// 64x7 pattern table, bit order G..A
	function automatic logic [6:0] segment_pattern_array(input logic [CODE_W-1:0] c);
		logic [6:0] p;
		logic [4:0] b;
		p = 7'h00;
		b = c[4:0];
		case (c)
			6'h00: p = 7'h3f;
			6'h01: p = 7'h06;
			6'h02: p = 7'h5b;
			6'h03: p = 7'h4f;
			6'h04: p = 7'h66;
			6'h05: p = 7'h6d;
			6'h06: p = 7'h7d;
			6'h07: p = 7'h07;
			6'h08: p = 7'h7f;
			6'h09: p = 7'h6f;
			6'h0a: p = 7'h77;
			6'h0b: p = 7'h7c;
			6'h0c: p = 7'h39;
			6'h0d: p = 7'h5e;
			6'h0e: p = 7'h79;
			6'h0f: p = 7'h71;
			6'h10: p = 7'h00;
			6'h11: p = 7'h0e;
			6'h12: p = 7'h38;
			6'h13: p = 7'h73;
			6'h14: p = 7'h3e;
			6'h15: p = 7'h58;
			6'h16: p = 7'h74;
			6'h17: p = 7'h18;
			6'h18: p = 7'h54;
			6'h19: p = 7'h5c;
			6'h1a: p = 7'h50;
			6'h1b: p = 7'h78;
			6'h1c: p = 7'h1c;
			6'h1d: p = 7'h6e;
			6'h1e: p = 7'h76;
			6'h1f: p = 7'h46;
			6'h3c: p = 7'h04;
			6'h3d: p = 7'h08;
			6'h3e: p = 7'h0f;
			6'h3f: p = 7'h1f;
			default: begin
				// codes 32..59: weighted bits A,F,B,G,E
				p[SEG_A] = b[0];
				p[SEG_F] = b[1];
				p[SEG_B] = b[2];
				p[SEG_G] = b[3];
				p[SEG_E] = b[4];
			end
		endcase
		return p;
	endfunction

	// digit latches; a single write wins over the bulk load
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int i = 0; i < DIGITS; i++) begin
				code_q[i] <= CODE_RESET;
			end
			h_q <= '0;
		end else begin
			if (reg_wr) begin
				// digit i takes nibble 6-i; top nibble is dropped
				for (int i = 0; i < DIGITS; i++) begin
					code_q[i] <= {2'b00, main_working_register[4*(DIGITS-1-i) +: 4]};
				end
				h_q <= reg_h;
			end
			if (digit_wr && digit_sel <= DIGIT_LAST) begin
				code_q[digit_sel] <= digit_code;
				h_q[digit_sel]    <= digit_h;
			end
		end
	end

	// phase timer and common rotation, free of software
	always_ff @(posedge core_clk) begin
		if (!resetn || mode_off) begin
			phase_cnt <= '0;
			com_idx   <= COM_RESET;
		end else if (phase_cnt == PHASE_LAST) begin
			phase_cnt <= '0;
			com_idx   <= com_idx + 2'd1;
		end else begin
			phase_cnt <= phase_cnt + 1'b1;
		end
	end

	// select data for the coming common; fixed wiring keeps failures meaningless
	always_comb begin
		logic [6:0] p;
		logic [1:0] k;
		p = 7'h00;
		k = (phase_cnt == PHASE_LAST) ? com_idx + 2'd1 : com_idx;
		next_sel = '0;
		for (int i = 0; i < DIGITS; i++) begin
			p = segment_pattern_array(code_q[i]);
			case (k)
				2'd0: begin
					next_sel[2*i]   = p[SEG_C];
					next_sel[2*i+1] = p[SEG_A];
				end
				2'd1: begin
					next_sel[2*i]   = p[SEG_F];
					next_sel[2*i+1] = p[SEG_B];
				end
				2'd2: begin
					next_sel[2*i]   = h_q[i];
					next_sel[2*i+1] = p[SEG_D];
				end
				default: begin
					next_sel[2*i]   = p[SEG_E];
					next_sel[2*i+1] = p[SEG_G];
				end
			endcase
		end
	end

	// registered glass outputs
	always_ff @(posedge core_clk) begin
		if (!resetn || mode_off) begin
			com_on      <= '0;
			sel_on      <= '0;
			scan_active <= 1'b0;
		end else begin
			com_on      <= COM_FIRST << ((phase_cnt == PHASE_LAST) ? com_idx + 2'd1 : com_idx);
			sel_on      <= next_sel;
			scan_active <= 1'b1;
		end
	end

	// one common at a time while scanning
	one_common_a: assert property (@(posedge core_clk) disable iff (!resetn)
		scan_active |-> $onehot(com_on))
		else $error("common drive not one-hot");

	// commons advance in order
	com_order_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && !mode_off && $past(scan_active) && com_on != $past(com_on))
		|-> com_on == {$past(com_on[2:0]), $past(com_on[3])})
		else $error("common order broken");

	sequence load_seven_s;
		reg_wr && !(digit_wr && digit_sel == 3'h0);
	endsequence

	sequence first_quiet_s;
		!reg_wr && !(digit_wr && digit_sel == 3'h0);
	endsequence

	// nibble six lands in digit 1 and stays while nothing reloads it
	digit_map_a: assert property (@(posedge core_clk) disable iff (!resetn)
		load_seven_s ##1 first_quiet_s [*2]
		|-> code_q[0] == {2'b00, $past(main_working_register[27:24], 2)})
		else $error("digit one not from nibble six");

	// top nibble never reaches a latch
	top_hidden_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_wr && !(digit_wr && digit_sel == 3'h6))
		|=> code_q[DIGITS-1] == {2'b00, $past(main_working_register[3:0])})
		else $error("digit seven not from nibble zero");

	// h bit on odd select common 3
	h_direct_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && com_on == 4'h4 && $stable(h_q) && $past(com_on) == 4'h4)
		|-> sel_on[0] == h_q[0])
		else $error("h segment mismatch");

	// blank code shows nothing beyond h
	blank_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $stable(code_q[0]) && code_q[0] == CODE_RESET && com_on == 4'h1
		 && $past(com_on) == 4'h1) |-> sel_on[1:0] == 2'b00)
		else $error("blank code lit");

	// eight lights even select on common one (segment a)
	eight_a_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $stable(code_q[1]) && code_q[1] == 6'h08 && com_on == 4'h1
		 && $past(com_on) == 4'h1) |-> sel_on[3:2] == 2'b11)
		else $error("eight pattern wrong");

	// code 60 lights only c: odd common 1 on, even off
	code60_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $stable(code_q[4]) && code_q[4] == 6'h3c && com_on == 4'h1
		 && $past(com_on) == 4'h1) |-> sel_on[9:8] == 2'b01)
		else $error("code sixty wrong");

	// code 26 lights e and g on common 4
	code26_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $stable(code_q[5]) && code_q[5] == 6'h1a && com_on == 4'h8
		 && $past(com_on) == 4'h8) |-> sel_on[11:10] == 2'b11)
		else $error("code twenty-six wrong");

	// off mode stops the drive
	off_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
		mode_off |=> (com_on == '0 && sel_on == '0 && !scan_active))
		else $error("drive while off");

	sequence com_held_s(logic [COMMONS-1:0] c);
		scan_active && com_on == c && $past(com_on) == c;
	endsequence

	// counter never runs past the last phase cycle
	phase_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
		phase_cnt <= PHASE_LAST)
		else $error("phase counter overrun");

	// a common holds for its whole phase
	com_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $past(scan_active) && phase_cnt != '0) |-> $stable(com_on))
		else $error("common moved mid phase");

	// and moves on when the phase wraps
	com_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(scan_active && $past(scan_active) && phase_cnt == '0) |-> com_on != $past(com_on))
		else $error("common did not advance");

	// no stray drive while idle
	idle_dark_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!scan_active |-> (com_on == '0 && sel_on == '0))
		else $error("drive while idle");

	// scan starts by itself, software never kicks it
	auto_scan_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!mode_off |=> scan_active)
		else $error("scan not running");

	// single load lands in its digit
	digit_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(digit_wr && digit_sel == 3'h0) |=> (code_q[0] == $past(digit_code) && h_q[0] == $past(digit_h)))
		else $error("single load lost");

	// bulk load carries the h bits too
	bulk_h_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_wr && !(digit_wr && digit_sel == 3'h6)) |=> h_q[DIGITS-1] == $past(reg_h[DIGITS-1]))
		else $error("bulk h bit lost");

	// select 7 is no digit and changes nothing
	sel_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(digit_wr && digit_sel == 3'h7 && !reg_wr) |=> $stable(h_q))
		else $error("digit seven select not ignored");

	// h of digit 7 shows on its odd select during common 3
	h_last_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(com_held_s(4'h4) ##0 $stable(h_q)) |-> sel_on[12] == h_q[DIGITS-1])
		else $error("last digit h mismatch");

	// blank digit 7 leaves both its selects dark on common 4
	last_blank_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(com_held_s(4'h8) ##0 ($stable(code_q[DIGITS-1]) && code_q[DIGITS-1] == CODE_RESET))
		|-> sel_on[13:12] == 2'b00)
		else $error("last digit blank lit");

	// code 63 on common 2: f dark, b lit
	code63_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(com_held_s(4'h2) ##0 ($stable(code_q[0]) && code_q[0] == 6'h3f))
		|-> sel_on[1:0] == 2'b10)
		else $error("code sixty-three wrong");

	// minus sign in digit 4 lights only g on common 4
	code40_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(com_held_s(4'h8) ##0 ($stable(code_q[3]) && code_q[3] == 6'h28))
		|-> sel_on[7:6] == 2'b10)
		else $error("code forty wrong");

	// a one lights c but not a on common 1
	code1_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(com_held_s(4'h1) ##0 ($stable(code_q[0]) && code_q[0] == 6'h01))
		|-> sel_on[1:0] == 2'b01)
		else $error("code one wrong");
endmodule
`default_nettype wire

// ==== logic/lcdsd_pkg.sv ====
// constants for the seven-digit segment decoder and lcd scan
package lcdsd_pkg;
	localparam int unsigned DIGITS      = 7;
	localparam int unsigned CODE_W      = 6;
	localparam int unsigned COMMONS     = 4;
	localparam int unsigned SELECTS     = 14;
	localparam int unsigned NIBBLES     = 8;
	localparam int unsigned SEG_COUNT   = COMMONS * SELECTS;
	// segment bit positions in a pattern word
	localparam int unsigned SEG_A = 0;
	localparam int unsigned SEG_B = 1;
	localparam int unsigned SEG_C = 2;
	localparam int unsigned SEG_D = 3;
	localparam int unsigned SEG_E = 4;
	localparam int unsigned SEG_F = 5;
	localparam int unsigned SEG_G = 6;
	// one common phase lasts this long
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned PHASE_US       = 2;
	localparam int unsigned PHASE_CYCLES   = PHASE_US * CLK_MHZ;
	localparam int unsigned PHASE_CNT_W    = 9;
	localparam logic [PHASE_CNT_W-1:0] PHASE_LAST = PHASE_CNT_W'(PHASE_CYCLES - 1);
	localparam logic [1:0]             COM_RESET  = 2'h0;
	localparam logic [COMMONS-1:0]     COM_FIRST  = 4'h1;
	localparam logic [CODE_W-1:0]      CODE_RESET = 6'h10;
	localparam logic [2:0]             DIGIT_LAST = 3'h6;
endpackage

// ==== dv/lcdsd_glass.sv ====
// glass model: rebuilds the lit segments of each digit from the scan lines
`timescale 1ns/100ps
`default_nettype none
module lcdsd_glass
	import lcdsd_pkg::*;
(
	// scan lines from the driver
	input  wire logic               core_clk,
	input  wire logic [COMMONS-1:0] com_on,
	input  wire logic [SELECTS-1:0] sel_on,
	// lit segments per digit, bit 7 is h
	output logic [7:0]              seg [DIGITS]
);
	// glass wiring is fixed, so the segment behind each line is a constant
	localparam int ODD_SEG [COMMONS]  = '{SEG_C, SEG_F, 7, SEG_E};
	localparam int EVEN_SEG [COMMONS] = '{SEG_A, SEG_B, SEG_D, SEG_G};

	// a segment only changes while its common is the single active one
	always_ff @(posedge core_clk) begin
		for (int k = 0; k < COMMONS; k++) begin
			if (com_on === COMMONS'(1 << k)) begin
				for (int i = 0; i < DIGITS; i++) begin
					seg[i][ODD_SEG[k]] <= sel_on[2*i];
					seg[i][EVEN_SEG[k]] <= sel_on[2*i+1];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the segment decoder and lcd scan
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import lcdsd_pkg::*;
	// codes 31 down to 0, bits g..a
	localparam logic [255:0] LOW_TAB = 256'h4676_6E1C_7850_5C54_1874_583E_7338_0E00_7179_5E39_7C77_6F7F_077D_6D66_4F5B_063F;
	localparam logic [31:0]  HI_TAB  = 32'h1F0F_0804;
	logic                    core_clk;
	logic                    resetn;
	logic                    digit_wr;
	logic [2:0]              digit_sel;
	logic [CODE_W-1:0]       digit_code;
	logic                    digit_h;
	logic                    reg_wr;
	logic [4*NIBBLES-1:0]    main_working_register;
	logic [DIGITS-1:0]       reg_h;
	logic                    mode_off;
	logic [COMMONS-1:0]      com_on;
	logic [SELECTS-1:0]      sel_on;
	logic                    scan_active;
	logic [7:0]              seg [DIGITS];
	int                      n_errors;
	int                      n_compared;

	lcdsd_decoder u_lcdsd_decoder (.core_clk, .resetn, .digit_wr, .digit_sel, .digit_code,
		.digit_h, .reg_wr, .main_working_register, .reg_h, .mode_off, .com_on, .sel_on,
		.scan_active);
	lcdsd_glass u_lcdsd_glass (.core_clk, .com_on, .sel_on, .seg);

	function automatic logic [6:0] pat(int c);
		logic [4:0] v;
		v = 5'(c - 32);
		if (c < 32) return LOW_TAB[8*c +: 7];
		if (c > 59) return HI_TAB[8*(c-60) +: 7];
		return {v[3], v[1], v[4], 2'b00, v[2], v[0]};
	endfunction

	task automatic chk(string name, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// one full rotation of the four commons plus margin
	task automatic frame();
		repeat (4 * PHASE_CYCLES + 10) @(negedge core_clk);
	endtask

	task automatic t_reset();
		repeat (2) @(negedge core_clk);
		chk("com_on in reset", 0, com_on);
		chk("active in reset", 0, scan_active);
		resetn = 1;
		@(negedge core_clk);
		chk("com_on first", COM_FIRST, com_on);
		chk("active", 1, scan_active);
		frame();
		chk("blank digit", 0, seg[0]);
		$display("test reset done");
	endtask

	// back to back single loads, seven codes per frame
	task automatic t_table();
		for (int b = 0; b < 64; b += 7) begin
			for (int d = 0; d < DIGITS; d++) begin
				digit_wr = 1;
				digit_sel = 3'(d);
				digit_code = 6'(b + d);
				digit_h = d[0];
				@(negedge core_clk);
			end
			digit_wr = 0;
			frame();
			for (int d = 0; d < DIGITS; d++)
				chk("pattern", {d[0], pat((b + d) % 64)}, seg[d]);
		end
		$display("test table done");
	endtask

	// bulk load with a single load to digit 4 in the same cycle
	task automatic t_bulk();
		reg_wr = 1;
		main_working_register = 32'hF123_4567;
		reg_h = 7'h53;
		digit_wr = 1;
		digit_sel = 3'h3;
		digit_code = 6'h28;
		digit_h = 0;
		@(negedge core_clk);
		reg_wr = 0;
		// select 7 names no digit and must be ignored
		digit_sel = 3'h7;
		digit_code = 6'h08;
		digit_h = 1;
		@(negedge core_clk);
		digit_wr = 0;
		frame();
		for (int i = 0; i < DIGITS; i++)
			chk("bulk digit", {i != 3 && reg_h[i], pat(i == 3 ? 40 : i + 1)}, seg[i]);
		$display("test bulk done");
	endtask

	task automatic t_off();
		mode_off = 1;
		repeat (2) @(negedge core_clk);
		chk("com_on off", 0, com_on);
		chk("sel_on off", 0, sel_on);
		chk("active off", 0, scan_active);
		mode_off = 0;
		// the first phase after a restart is one cycle short
		repeat (PHASE_CYCLES - 1) @(negedge core_clk);
		chk("com_on held", COM_FIRST, com_on);
		@(negedge core_clk);
		chk("com_on next", 4'h2, com_on);
		$display("test off done");
	endtask

	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end

	// whole run is about 12k cycles
	initial begin
		#400_000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		{resetn, digit_wr, digit_sel, digit_code, digit_h, reg_wr} = 0;
		{main_working_register, reg_h, mode_off} = 0;
		n_errors = 0;
		n_compared = 0;
		t_reset();
		t_table();
		t_bulk();
		t_off();
		tally_and_finish();
	end
endmodule
`default_nettype wire
